//--- src/tmw_pkg.sv
// Package: register map, field layout, reset values and modes of the 8-bit waveform timer
package tmw_pkg;

  // ==========================================================================
  // Register byte addresses (APB, one aligned word each)
  localparam logic [7:0] TMW_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] TMW_ADDR_COUNT  = 8'h04;
  localparam logic [7:0] TMW_ADDR_CMP    = 8'h08;
  localparam logic [7:0] TMW_ADDR_STATUS = 8'h0c;

  // ==========================================================================
  // Control register fields
  localparam int TMW_CTRL_MODE_LSB  = 0;
  localparam int TMW_CTRL_ACT_LSB   = 2;
  localparam int TMW_CTRL_CLK_LSB   = 4;
  localparam int TMW_CTRL_FORCE_BIT = 7;

  // Status register fields (flag bits write one to clear)
  localparam int TMW_STAT_CMP_BIT = 0;
  localparam int TMW_STAT_OVF_BIT = 1;
  localparam int TMW_STAT_OUT_BIT = 2;
  localparam int TMW_STAT_DIR_BIT = 3;

  // ==========================================================================
  // Reset values and count limits
  localparam logic [7:0] TMW_COUNT_RST = 8'h00;
  localparam logic [7:0] TMW_CMP_RST   = 8'h00;
  localparam logic [7:0] TMW_BOTTOM    = 8'h00;
  localparam logic [7:0] TMW_MAX       = 8'hff;

  // Prescale limits, cycles of the 100 MHz clock per timer tick minus one
  localparam logic [9:0] TMW_DIV_8    = 10'd7;
  localparam logic [9:0] TMW_DIV_64   = 10'd63;
  localparam logic [9:0] TMW_DIV_256  = 10'd255;
  localparam logic [9:0] TMW_DIV_1024 = 10'd1023;

  // ==========================================================================
  // Modes and selections
  typedef enum logic [1:0] {
    TMW_MODE_NORMAL = 2'h0,
    TMW_MODE_PHASE  = 2'h1,
    TMW_MODE_CLEAR  = 2'h2,
    TMW_MODE_FAST   = 2'h3
  } tmw_mode_t;

  typedef enum logic [2:0] {
    TMW_CLK_STOP = 3'h0,
    TMW_CLK_DIV1 = 3'h1,
    TMW_CLK_DIV8 = 3'h2,
    TMW_CLK_D64  = 3'h3,
    TMW_CLK_D256 = 3'h4,
    TMW_CLK_D1K  = 3'h5
  } tmw_clk_t;

  // Counting direction, one-hot
  typedef enum logic [1:0] {
    TMW_DIR_UP   = 2'b01,
    TMW_DIR_DOWN = 2'b10
  } tmw_dir_t;

  // APB request and answer carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tmw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmw_apb_rsp_t;

endpackage

//--- src/tmw_timer.sv
// 8-bit timer with clear-on-match, fast PWM and phase-correct PWM waveform modes
`timescale 1ns/10ps

// Summary of operation
// - Mode 2 counts up, clears at compare
// - Clear mode compare write is immediate
// - Clear mode action 1 toggles output
// - Clear mode raises compare flag at top
// - Clear mode overflow flag on max wrap
// - Mode 3 counts zero to max repeatedly
// - Fast mode clears after max tick
// - Fast: clear match set bottom, or inverted
// - Fast mode overflow flag at max
// - Fast period is 256 ticks
// - Fast extremes: spike at zero, constant max
// - Fast action 1 toggles, compare buffered
// - Mode 1 counts up then down
// - Phase mode holds max one tick
// - Phase: clear up match, set down
// - Phase mode overflow flag at bottom
// - Phase period is 510 ticks
// - Phase extremes: zero low, max high
// - At max output takes up-match result unless compare is max
// - Synchronous, tick enable, five prescales
// - Match sets flag at next tick
// - PWM compare writes buffered to top (max)
// - Count write blocks next tick's match
// - Non-PWM force strobe acts without flag or clear
module tmw_timer (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  srst_in,
  // APB slave
  input  wire tmw_pkg::tmw_apb_req_t apb_req_in,
  output tmw_pkg::tmw_apb_rsp_t      apb_rsp_out,
  // Waveform pin
  output logic                       compare_output_out,
  output logic                       compare_output_oe_out,
  // Flags to the interrupt controller, and the timer tick enable
  output logic                       compare_match_flag_out,
  output logic                       overflow_flag_out,
  output logic                       timer_tick_out
);
  import tmw_pkg::*;

  // ==========================================================================
  // Registers
  tmw_mode_t  waveform_mode_select;
  logic [1:0] output_action_select;
  tmw_clk_t   clock_select;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic       compare_match_flag;
  logic       overflow_flag;
  logic       waveform_output_level;
  tmw_dir_t   count_dir;
  logic       count_written;
  logic       timer_tick;
  logic [9:0] prescale_cnt;

  // ==========================================================================
  // APB decode
  logic wr_en;
  logic rd_en;
  logic hit;
  logic force_compare_strobe;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_stat;

  assign wr_en   = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
  assign rd_en   = apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite;
  assign hit     = (apb_req_in.paddr == TMW_ADDR_CTRL) || (apb_req_in.paddr == TMW_ADDR_COUNT)
                || (apb_req_in.paddr == TMW_ADDR_CMP) || (apb_req_in.paddr == TMW_ADDR_STATUS);
  assign wr_ctrl  = wr_en && (apb_req_in.paddr == TMW_ADDR_CTRL);
  assign wr_count = wr_en && (apb_req_in.paddr == TMW_ADDR_COUNT);
  assign wr_cmp   = wr_en && (apb_req_in.paddr == TMW_ADDR_CMP);
  assign wr_stat  = wr_en && (apb_req_in.paddr == TMW_ADDR_STATUS);
  assign force_compare_strobe = wr_ctrl && apb_req_in.pwdata[TMW_CTRL_FORCE_BIT];

  logic is_pwm;
  assign is_pwm = (waveform_mode_select == TMW_MODE_PHASE)
               || (waveform_mode_select == TMW_MODE_FAST);

  // ==========================================================================
  // Prescaler: one-cycle tick enable
  logic [9:0] div_limit;
  always_comb begin
    case (clock_select)
      TMW_CLK_DIV8: div_limit = TMW_DIV_8;
      TMW_CLK_D64:  div_limit = TMW_DIV_64;
      TMW_CLK_D256: div_limit = TMW_DIV_256;
      TMW_CLK_D1K:  div_limit = TMW_DIV_1024;
      default:      div_limit = 10'h000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || clock_select == TMW_CLK_STOP) begin
      prescale_cnt <= 10'h000;
      timer_tick   <= 1'b0;
    end else if (prescale_cnt >= div_limit) begin
      prescale_cnt <= 10'h000;
      timer_tick   <= 1'b1;
    end else begin
      prescale_cnt <= prescale_cnt + 10'h001;
      timer_tick   <= 1'b0;
    end
  end

  // ==========================================================================
  // Match detection
  logic raw_match;
  logic match;
  logic at_max;
  logic at_bottom;
  logic clr_top;
  assign raw_match = (count_value == compare_value);
  // A write to the counter masks the match for the next tick
  assign match     = raw_match && !count_written;
  assign at_max    = (count_value == TMW_MAX);
  assign at_bottom = (count_value == TMW_BOTTOM);
  // A blocked match must not clear the counter either
  assign clr_top   = (waveform_mode_select == TMW_MODE_CLEAR) && match;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      count_written <= 1'b0;
    end else if (wr_count) begin
      count_written <= 1'b1;
    end else if (timer_tick) begin
      count_written <= 1'b0;
    end
  end

  // ==========================================================================
  // Counter and direction
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      count_value <= TMW_COUNT_RST;
      count_dir   <= TMW_DIR_UP;
    end else if (wr_count) begin
      count_value <= apb_req_in.pwdata[7:0];
    end else if (timer_tick) begin
      case (waveform_mode_select)
        TMW_MODE_CLEAR: begin
          // Top is the compare value; a lower value written late wraps via max
          count_value <= clr_top ? TMW_BOTTOM : count_value + 8'h01;
        end
        TMW_MODE_FAST: begin
          count_value <= at_max ? TMW_BOTTOM : count_value + 8'h01;
        end
        TMW_MODE_PHASE: begin
          case (count_dir)
            TMW_DIR_UP: begin
              if (at_max) begin
                count_dir   <= TMW_DIR_DOWN;
                count_value <= TMW_MAX - 8'h01;
              end else begin
                count_value <= count_value + 8'h01;
              end
            end
            TMW_DIR_DOWN: begin
              if (at_bottom) begin
                count_dir   <= TMW_DIR_UP;
                count_value <= TMW_BOTTOM + 8'h01;
              end else begin
                count_value <= count_value - 8'h01;
              end
            end
            default: count_dir <= TMW_DIR_UP;
          endcase
        end
        default: count_value <= count_value + 8'h01;
      endcase
    end
  end

  // ==========================================================================
  // Compare value and its double buffer
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      compare_buffer <= TMW_CMP_RST;
    end else if (wr_cmp) begin
      compare_buffer <= apb_req_in.pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      compare_value <= TMW_CMP_RST;
    end else if (wr_cmp && !is_pwm) begin
      compare_value <= apb_req_in.pwdata[7:0];
    end else if (timer_tick && waveform_mode_select == TMW_MODE_FAST && at_max) begin
      compare_value <= compare_buffer;
    end else if (timer_tick && waveform_mode_select == TMW_MODE_PHASE && at_max
                 && count_dir == TMW_DIR_UP) begin
      compare_value <= compare_buffer;
    end
  end

  // ==========================================================================
  // Flags: hardware set wins over a write-one clear in the same cycle
  logic set_cmp;
  logic set_ovf;
  assign set_cmp = timer_tick && match;
  always_comb begin
    case (waveform_mode_select)
      TMW_MODE_PHASE: set_ovf = timer_tick && at_bottom && count_dir == TMW_DIR_DOWN;
      TMW_MODE_FAST:  set_ovf = timer_tick && at_max;
      default:        set_ovf = timer_tick && at_max;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      compare_match_flag <= 1'b0;
    end else if (set_cmp) begin
      compare_match_flag <= 1'b1;
    end else if (wr_stat && apb_req_in.pwdata[TMW_STAT_CMP_BIT]) begin
      compare_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      overflow_flag <= 1'b0;
    end else if (set_ovf) begin
      overflow_flag <= 1'b1;
    end else if (wr_stat && apb_req_in.pwdata[TMW_STAT_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Waveform generator
  logic next_level;
  logic up_level;
  // Level after an up-counting match in phase mode; inverting selection sets it
  assign up_level = output_action_select[0];

  always_comb begin
    next_level = waveform_output_level;
    if (force_compare_strobe && !is_pwm) begin
      // Forced match uses the action bits being written now
      case (apb_req_in.pwdata[TMW_CTRL_ACT_LSB +: 2])
        2'h1:    next_level = !waveform_output_level;
        2'h2:    next_level = 1'b0;
        2'h3:    next_level = 1'b1;
        default: next_level = waveform_output_level;
      endcase
    end else if (timer_tick) begin
      case (waveform_mode_select)
        TMW_MODE_FAST: begin
          if (output_action_select == 2'h1) begin
            if (match) next_level = !waveform_output_level;
          end else if (output_action_select[1]) begin
            // At max the match is ignored and bottom sets the level for the whole period
            if (at_max) next_level = !output_action_select[0];
            else if (match) next_level = output_action_select[0];
          end
        end
        TMW_MODE_PHASE: begin
          if (output_action_select[1]) begin
            if (count_dir == TMW_DIR_UP && at_max) begin
              // Symmetry fix: max shows the up-count result, inverted when compare is max
              next_level = (compare_value == TMW_MAX) ? !up_level : up_level;
            end else if (match && count_dir == TMW_DIR_UP) begin
              next_level = up_level;
            end else if (match && count_dir == TMW_DIR_DOWN) begin
              // A zero compare sits on the bottom turn, where both slopes meet
              next_level = (compare_value == TMW_BOTTOM) ? up_level : !up_level;
            end
          end
        end
        default: begin
          if (match) begin
            case (output_action_select)
              2'h1:    next_level = !waveform_output_level;
              2'h2:    next_level = 1'b0;
              2'h3:    next_level = 1'b1;
              default: next_level = waveform_output_level;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      waveform_output_level <= 1'b0;
    end else begin
      waveform_output_level <= next_level;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      waveform_mode_select <= TMW_MODE_NORMAL;
      output_action_select <= 2'h0;
      clock_select         <= TMW_CLK_STOP;
    end else if (wr_ctrl) begin
      waveform_mode_select <= tmw_mode_t'(apb_req_in.pwdata[TMW_CTRL_MODE_LSB +: 2]);
      output_action_select <= apb_req_in.pwdata[TMW_CTRL_ACT_LSB +: 2];
      clock_select         <= tmw_clk_t'(apb_req_in.pwdata[TMW_CTRL_CLK_LSB +: 3]);
    end
  end

  // ==========================================================================
  // Read data, captured in the setup cycle so it stands at the access edge;
  // a value that moves in the access cycle is read one cycle old
  logic [31:0] next_rdata;
  logic [31:0] rdata_q;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (apb_req_in.paddr)
      TMW_ADDR_CTRL: begin
        next_rdata[TMW_CTRL_MODE_LSB +: 2] = waveform_mode_select;
        next_rdata[TMW_CTRL_ACT_LSB +: 2]  = output_action_select;
        next_rdata[TMW_CTRL_CLK_LSB +: 3]  = clock_select;
      end
      TMW_ADDR_COUNT:  next_rdata[7:0] = count_value;
      TMW_ADDR_CMP:    next_rdata[7:0] = is_pwm ? compare_buffer : compare_value;
      TMW_ADDR_STATUS: begin
        next_rdata[TMW_STAT_CMP_BIT] = compare_match_flag;
        next_rdata[TMW_STAT_OVF_BIT] = overflow_flag;
        next_rdata[TMW_STAT_OUT_BIT] = waveform_output_level;
        next_rdata[TMW_STAT_DIR_BIT] = (count_dir == TMW_DIR_DOWN);
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite) begin
      rdata_q <= next_rdata;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign apb_rsp_out = '{pready:  1'b1,
                         pslverr: rd_en && !hit || wr_en && !hit,
                         prdata:  rdata_q};

  // ==========================================================================
  // Outputs; the port direction bit stays with software outside
  assign compare_output_out     = waveform_output_level;
  assign compare_output_oe_out  = (output_action_select != 2'h0);
  assign compare_match_flag_out = compare_match_flag;
  assign overflow_flag_out      = overflow_flag;
  assign timer_tick_out         = timer_tick;

endmodule

//--- sim/tmw_load.sv
// Board load model on the compare output pin
`timescale 1ns/10ps
module tmw_load (
  // From the timer
  input  wire logic level_in,
  input  wire logic oe_in,
  // Resolved pin
  output logic      pin_out
);
  // ==========================================
  // Pin resolution
  // A pull-down holds the pin low while the timer leaves it undriven
  assign pin_out = oe_in ? level_in : 1'b0;
endmodule

//--- sim/tmw_chk.sv
// Port checker for the waveform timer
`timescale 1ns/10ps
module tmw_chk
  import tmw_pkg::*;
(
  // Clock, reset and bus
  input wire logic                  sys_clk_in,
  input wire logic                  srst_in,
  input wire tmw_pkg::tmw_apb_req_t apb_req_in,
  input wire tmw_pkg::tmw_apb_rsp_t apb_rsp_out,
  // Timer outputs
  input wire logic                  compare_output_out,
  input wire logic                  compare_output_oe_out,
  input wire logic                  compare_match_flag_out,
  input wire logic                  overflow_flag_out,
  input wire logic                  timer_tick_out
);
  logic       acc;
  logic       ctl_wr;
  logic [7:0] ctl_q;
  logic [4:0] age;
  // ==========================================
  // Shadow of the control register
  assign acc = apb_req_in.psel && apb_req_in.penable;
  assign ctl_wr = acc && apb_req_in.pwrite && apb_req_in.paddr == TMW_ADDR_CTRL;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctl_q <= 8'h00;
    end else if (ctl_wr) begin
      ctl_q <= apb_req_in.pwdata[7:0];
    end
  end
  // Prescaler may restart on a new selection, so spacing is judged once settled
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || (ctl_wr && apb_req_in.pwdata[6:4] != ctl_q[6:4])) begin
      age <= 5'h00;
    end else if (age != 5'h1f) begin
      age <= age + 5'h01;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  chk_reset_clear: assert property (
    $fell(srst_in) |-> !compare_output_out && !compare_match_flag_out && !overflow_flag_out)
    else $error("state not clear after reset");
  chk_pin_enable: assert property (
    compare_output_oe_out == (ctl_q[3:2] != 2'h0))
    else $error("pin enable does not follow action select");
  chk_level_on_tick: assert property (
    $changed(compare_output_out) |-> $past(timer_tick_out) || $past(ctl_wr))
    else $error("output level moved without a tick");
  chk_match_flag_tick: assert property (
    $rose(compare_match_flag_out) |-> $past(timer_tick_out))
    else $error("compare flag set without a tick");
  chk_ovf_flag_tick: assert property (
    $rose(overflow_flag_out) |-> $past(timer_tick_out))
    else $error("overflow flag set without a tick");
  chk_stop_no_tick: assert property (
    ctl_q[6:4] == 3'h0 && age > 5'd2 |-> !timer_tick_out)
    else $error("tick while stopped");
  chk_div8_spacing: assert property (
    timer_tick_out && ctl_q[6:4] == 3'h2 && age > 5'd20
      |=> !timer_tick_out [*7] ##1 timer_tick_out)
    else $error("divide by 8 tick spacing wrong");
  chk_err_in_access: assert property (
    apb_rsp_out.pslverr |-> acc)
    else $error("slave error outside access phase");
  chk_err_unmapped: assert property (
    acc && apb_req_in.paddr[7:4] != 4'h0 |-> apb_rsp_out.pslverr && apb_rsp_out.pready)
    else $error("unmapped access not refused");
endmodule

bind tmw_timer tmw_chk tmw_chk_inst (
  .sys_clk_in             (sys_clk_in),
  .srst_in                (srst_in),
  .apb_req_in             (apb_req_in),
  .apb_rsp_out            (apb_rsp_out),
  .compare_output_out     (compare_output_out),
  .compare_output_oe_out  (compare_output_oe_out),
  .compare_match_flag_out (compare_match_flag_out),
  .overflow_flag_out      (overflow_flag_out),
  .timer_tick_out         (timer_tick_out)
);

//--- sim/tmw_timer_tb.sv
// Self-checking bench for the waveform timer
`timescale 1ns/10ps
module tmw_timer_tb;
  import tmw_pkg::*;
  logic         sys_clk_in;
  logic         srst_in;
  tmw_apb_req_t req;
  tmw_apb_rsp_t rsp;
  logic         cmp_out;
  logic         cmp_oe;
  logic         pin;
  logic         tick;
  logic         cflag;
  logic         oflag;
  logic [31:0]  rd;
  logic         err;
  int           fails;
  int           check_count;
  int           hi;
  int           lo;
  int           n;
  // Waveform cases: mode, action, compare, high ticks, period
  logic [7:0]   wm[6] = '{3, 3, 3, 1, 1, 3};
  logic [7:0]   wa[6] = '{2, 2, 3, 2, 3, 1};
  logic [7:0]   wc[6] = '{0, 64, 64, 64, 64, 64};
  int           wh[6] = '{1, 65, 191, 128, 382, 256};
  int           wp[6] = '{256, 256, 256, 510, 510, 512};
  // Constant-level cases: mode, action, compare, level
  logic [7:0]   km[5] = '{3, 3, 1, 1, 1};
  logic [7:0]   ka[5] = '{2, 3, 2, 2, 3};
  logic [7:0]   kc[5] = '{255, 255, 0, 255, 0};
  logic         kl[5] = '{1, 0, 0, 1, 1};
  int           tw[6] = '{100, 20, 160, 1280, 5120, 20480};

  tmw_timer tmw_timer_inst (
    .sys_clk_in             (sys_clk_in),
    .srst_in                (srst_in),
    .apb_req_in             (req),
    .apb_rsp_out            (rsp),
    .compare_output_out     (cmp_out),
    .compare_output_oe_out  (cmp_oe),
    .compare_match_flag_out (cflag),
    .overflow_flag_out      (oflag),
    .timer_tick_out         (tick)
  );
  tmw_load tmw_load_inst (
    .level_in (cmp_out),
    .oe_in    (cmp_oe),
    .pin_out  (pin)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // ==========================================
  // Tasks
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the access edge,
  // then one more edge lets a write settle before the caller looks at outputs
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    err = rsp.pslverr;
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 20) begin
      fails++;
      stop_test();
    end
    @(posedge sys_clk_in);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rd & m, e);
  endtask
  function automatic logic [31:0] cv(input logic [7:0] m, input logic [7:0] a,
                                     input logic [2:0] c);
    return {25'h0, c, a[1:0], m[1:0]};
  endfunction
  task automatic setup(input logic [7:0] c, input logic [31:0] ctl);
    srst_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    xfer(TMW_ADDR_CMP, 1'b1, {24'h0, c});
    xfer(TMW_ADDR_CTRL, 1'b1, ctl);
  endtask
  task automatic wait_pin(input logic v, output int c);
    c = 0;
    while (pin !== v && c < 3000) begin
      @(posedge sys_clk_in);
      c++;
    end
    if (c >= 3000) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic measure;
    wait_pin(1'b0, hi);
    wait_pin(1'b1, hi);
    wait_pin(1'b0, hi);
    wait_pin(1'b1, lo);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    fails = 0;
    check_count = 0;
    srst_in = 1'b1;
    req = '0;
    setup(8'ha5, 32'h0);
    foreach (tw[i]) rc(8'(4 * i), 32'hff, i == 2 ? 32'ha5 : 32'h0);
    rc(8'h10, 32'hffffffff, 32'h0);
    check(err, 1'b1);
    $display("Test reset and map done");
    setup(8'h05, cv(2, 1, 1));
    measure();
    check(hi, 6);
    check(hi + lo, 12);
    rc(TMW_ADDR_STATUS, 32'h3, 32'h1);
    check({oflag, cflag}, 2'b01);
    setup(8'h05, cv(2, 0, 0));
    xfer(TMW_ADDR_COUNT, 1'b1, 32'h5);
    xfer(TMW_ADDR_CTRL, 1'b1, cv(2, 0, 1));
    repeat (10) @(posedge sys_clk_in);
    rc(TMW_ADDR_STATUS, 32'h1, 32'h0);
    repeat (300) @(posedge sys_clk_in);
    rc(TMW_ADDR_STATUS, 32'h3, 32'h3);
    setup(8'h05, cv(2, 3, 0));
    xfer(TMW_ADDR_CTRL, 1'b1, cv(2, 3, 0) | 32'h80);
    check(cmp_out, 1'b1);
    rc(TMW_ADDR_STATUS, 32'h1, 32'h0);
    rc(TMW_ADDR_CTRL, 32'hff, cv(2, 3, 0));
    xfer(TMW_ADDR_CTRL, 1'b1, cv(2, 0, 0));
    check(cmp_oe, 1'b0);
    check(cmp_out, 1'b1);
    check(pin, 1'b0);
    $display("Test clear-on-match done");
    // Live compare stays 0x40 while the buffered 0x10 waits for the wrap
    setup(8'h40, cv(3, 2, 0));
    xfer(TMW_ADDR_CMP, 1'b1, 32'h10);
    xfer(TMW_ADDR_COUNT, 1'b1, 32'h20);
    xfer(TMW_ADDR_CTRL, 1'b1, cv(3, 2, 1));
    repeat (40) @(posedge sys_clk_in);
    rc(TMW_ADDR_STATUS, 32'h1, 32'h1);
    rc(TMW_ADDR_CMP, 32'hff, 32'h10);
    foreach (wm[i]) begin
      setup(wc[i], cv(wm[i], wa[i], 1));
      measure();
      check(hi, wh[i]);
      check(hi + lo, wp[i]);
      rc(TMW_ADDR_STATUS, 32'h3, 32'h3);
    end
    foreach (km[i]) begin
      setup(kc[i], cv(km[i], ka[i], 1));
      repeat (600) @(posedge sys_clk_in);
      for (n = 0; n < 600 && pin === kl[i]; n++) @(posedge sys_clk_in);
      check(pin, kl[i]);
    end
    $display("Test waveforms done");
    foreach (tw[i]) begin
      setup(8'h40, cv(3, 2, 3'(i)));
      n = 0;
      repeat (tw[i]) begin
        @(posedge sys_clk_in);
        n += int'(tick);
      end
      check(n, i == 0 ? 0 : 20);
    end
    $display("Test prescale done");
    stop_test();
  end
endmodule
